// ---- rs485_cfg_pkg.sv ----
// Operation
// - Link settings apply only after next power-on
// - Partial batch init keeps link settings
// - Full batch init restores link settings
// - Address sentinel -1 selects hardware switch
// - Bit-rate index, default four is 115200
// - Word order default: even high, big-endian
// - Parity setting, default even
// - Stop bits, default code zero, one bit
// - Reply waits transmission time, default 3 ms
// - Silent interval, zero means automatic
// - Alarm and response settings act immediately
// - Timeout alarm setting, zero disables monitoring
// - Error alarm threshold, default three
// - Error information threshold, default three
// - Error response mode, default exception reply
// - Thirty-two indirect slots, zero to thirty-one
// - Slot holds half address, lower word
// - Functions 03h/10h/17h on area use slot
package rs485_cfg_pkg;
    // Register word indices on the bus
    localparam logic [5:0] IDX_STATION = 6'h00;
    localparam logic [5:0] IDX_BAUD = 6'h01;
    localparam logic [5:0] IDX_ORDER = 6'h02;
    localparam logic [5:0] IDX_PARITY = 6'h03;
    localparam logic [5:0] IDX_STOP = 6'h04;
    localparam logic [5:0] IDX_TXWAIT = 6'h05;
    localparam logic [5:0] IDX_SILENT = 6'h06;
    localparam logic [5:0] IDX_TOALARM = 6'h07;
    localparam logic [5:0] IDX_ERRALARM = 6'h08;
    localparam logic [5:0] IDX_ERRINFO = 6'h09;
    localparam logic [5:0] IDX_ERRMODE = 6'h0a;
    localparam logic [5:0] IDX_MAINT = 6'h0b;
    localparam logic [5:0] IDX_STATUS = 6'h0c;
    localparam logic [5:0] IDX_ACTIVE = 6'h0d;
    localparam logic [5:0] IDX_SLOT0 = 6'h20;
    // Maintenance command codes
    localparam logic [1:0] CMD_BATCH = 2'h1;
    localparam logic [1:0] CMD_ALL = 2'h2;
    localparam logic [1:0] CMD_CLRALM = 2'h3;
    // Initial values
    localparam logic [15:0] STATION_RST = 16'hffff;
    localparam logic [3:0] BAUD_RST = 4'h4;
    localparam logic [1:0] ORDER_RST = 2'h0;
    localparam logic [1:0] PARITY_RST = 2'h1;
    localparam logic [1:0] STOP_RST = 2'h0;
    localparam logic [7:0] TXWAIT_RST = 8'h1e;
    localparam logic [7:0] SILENT_RST = 8'h00;
    localparam logic [7:0] TOALARM_RST = 8'h00;
    localparam logic [7:0] ERRALARM_RST = 8'h03;
    localparam logic [7:0] ERRINFO_RST = 8'h03;
    localparam logic ERRMODE_RST = 1'b1;
    // Automatic silent interval in 0.1 ms steps, slow and fast bit rates
    localparam logic [7:0] SILENT_AUTO_SLOW = 8'h28;
    localparam logic [7:0] SILENT_AUTO_FAST = 8'h12;
    localparam logic [3:0] BAUD_FAST_MIN = 4'h2;
    // Modbus function codes and address map
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h10;
    localparam logic [7:0] FN_RDWR = 8'h17;
    localparam logic [15:0] ASSIGN_BASE = 16'h1200;
    localparam logic [15:0] AREA_BASE = 16'h1300;
    localparam int SLOTS = 32;
    // Time base
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam logic [3:0] TICKS_PER_MS = 4'ha;
    localparam logic [1:0] BOOT_WAIT = 2'h3;
    // Slot assignments after initialization
    localparam logic [15:0] SLOT_RST [SLOTS] = '{
        16'h0240, 16'h0380, 16'h0300, 16'h0340, 16'h003e, 16'h0062, 16'h0067, 16'h006c,
        16'h003f, 16'h0040, 16'h007b, 16'h007c, 16'h00a3, 16'h009d, 16'h007f, 16'h007e,
        16'h00a0, 16'h00a1, 16'h00b8, 16'h00b9, 16'h00ba, 16'h00bb, 16'h00bc, 16'h00bd,
        16'h00be, 16'h00bf, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
endpackage : rs485_cfg_pkg

// ---- sync_bits.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    ////////////////////////////////////////////////////////////////////////
    // Two stages; the first is read by the second only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : sync_bits
`default_nettype wire

// ---- tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter int DIV = 2000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic restart,
    output logic tick
);
    logic [15:0] cnt_q, cnt_d;
    logic tick_d;
    ////////////////////////////////////////////////////////////////////////
    // Restart realigns the period so a delay starts exactly at the request
    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 16'h0001;
        if (restart) begin
            cnt_d = 16'h0000;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_d = 16'h0000;
            tick_d = 1'b1;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule : tick_gen
`default_nettype wire

// ---- rs485_slave_cfg.sv ----
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rs485_slave_cfg (
    input wire logic clock,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] addrSwitch,
    input wire logic frameOk,
    input wire logic frameErr,
    input wire logic replyReq,
    output logic replyGo,
    input wire logic qValid,
    input wire logic [7:0] qFunc,
    input wire logic [15:0] qAddr,
    input wire logic [15:0] qData,
    output logic fwdValid,
    output logic [15:0] fwdAddr,
    output logic [7:0] fwdFunc,
    output logic fwdReject,
    output logic [7:0] linkAddr,
    output logic [3:0] linkBaud,
    output logic [1:0] linkOrder,
    output logic [1:0] linkParity,
    output logic [1:0] linkStop,
    output logic [7:0] linkSilent,
    output logic timeoutAlarm,
    output logic errAlarm,
    output logic errInfo,
    output logic exceptMode
);
    // Stored and active configuration
    logic [15:0] station_q, station_d;
    logic [3:0] baud_q, baud_d;
    logic [1:0] order_q, order_d, parity_q, parity_d, stop_q, stop_d;
    logic [7:0] txWait_q, txWait_d, silent_q, silent_d;
    logic [7:0] toSet_q, toSet_d, errThr_q, errThr_d, infoThr_q, infoThr_d;
    localparam int SLOTS = rs485_cfg_pkg::SLOTS;
    logic errMode_q, errMode_d;
    logic [15:0] slot_q [SLOTS];
    logic [15:0] slot_d [SLOTS];
    logic [31:0] rdata_d;
    logic wait_d, clrAlm;
    logic [1:0] boot_q, boot_d;
    logic [7:0] linkAddr_d, linkSilent_d, activeWait_q, activeWait_d;
    logic [3:0] linkBaud_d;
    logic [1:0] linkOrder_d, linkParity_d, linkStop_d;
    logic [7:0] swSync;
    logic tick, replyTick;
    // Declared up here because the status read-back uses them
    logic [7:0] errCnt_q, errCnt_d, toMs_q, toMs_d;

    sync_bits #(.W(8)) uSwitch (
        .clock(clock),
        .rst(rst),
        .asyncIn(addrSwitch),
        .syncOut(swSync)
    );
    tick_gen #(.DIV(rs485_cfg_pkg::TICK_CYCLES)) uFreeTick (
        .clock(clock),
        .rst(rst),
        .restart(1'b0),
        .tick(tick)
    );
    tick_gen #(.DIV(rs485_cfg_pkg::TICK_CYCLES)) uReplyTick (
        .clock(clock),
        .rst(rst),
        .restart(replyReq),
        .tick(replyTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: waitrequest drops for one cycle, write lands at that edge
    always_comb begin
        logic wrHit;
        logic [1:0] cmd;
        wrHit = write && !waitrequest;
        cmd = writedata[1:0];
        wait_d = !((read || write) && waitrequest);
        station_d = station_q;
        baud_d = baud_q;
        order_d = order_q;
        parity_d = parity_q;
        stop_d = stop_q;
        txWait_d = txWait_q;
        silent_d = silent_q;
        toSet_d = toSet_q;
        errThr_d = errThr_q;
        infoThr_d = infoThr_q;
        errMode_d = errMode_q;
        slot_d = slot_q;
        clrAlm = 1'b0;
        if (wrHit) begin
            case (address)
                rs485_cfg_pkg::IDX_STATION: station_d = writedata[15:0];
                rs485_cfg_pkg::IDX_BAUD: baud_d = writedata[3:0];
                rs485_cfg_pkg::IDX_ORDER: order_d = writedata[1:0];
                rs485_cfg_pkg::IDX_PARITY: parity_d = writedata[1:0];
                rs485_cfg_pkg::IDX_STOP: stop_d = writedata[1:0];
                rs485_cfg_pkg::IDX_TXWAIT: txWait_d = writedata[7:0];
                rs485_cfg_pkg::IDX_SILENT: silent_d = writedata[7:0];
                rs485_cfg_pkg::IDX_TOALARM: toSet_d = writedata[7:0];
                rs485_cfg_pkg::IDX_ERRALARM: errThr_d = writedata[7:0];
                rs485_cfg_pkg::IDX_ERRINFO: infoThr_d = writedata[7:0];
                rs485_cfg_pkg::IDX_ERRMODE: errMode_d = writedata[0];
                rs485_cfg_pkg::IDX_MAINT: begin
                    // Batch init leaves link settings alone, full init restores them
                    if (cmd == rs485_cfg_pkg::CMD_BATCH || cmd == rs485_cfg_pkg::CMD_ALL) begin
                        toSet_d = rs485_cfg_pkg::TOALARM_RST;
                        errThr_d = rs485_cfg_pkg::ERRALARM_RST;
                        infoThr_d = rs485_cfg_pkg::ERRINFO_RST;
                        errMode_d = rs485_cfg_pkg::ERRMODE_RST;
                        slot_d = rs485_cfg_pkg::SLOT_RST;
                    end
                    if (cmd == rs485_cfg_pkg::CMD_ALL) begin
                        station_d = rs485_cfg_pkg::STATION_RST;
                        baud_d = rs485_cfg_pkg::BAUD_RST;
                        order_d = rs485_cfg_pkg::ORDER_RST;
                        parity_d = rs485_cfg_pkg::PARITY_RST;
                        stop_d = rs485_cfg_pkg::STOP_RST;
                        txWait_d = rs485_cfg_pkg::TXWAIT_RST;
                        silent_d = rs485_cfg_pkg::SILENT_RST;
                    end
                    clrAlm = (cmd == rs485_cfg_pkg::CMD_CLRALM);
                end
                default: begin
                    if (address[5]) begin
                        slot_d[address[4:0]] = writedata[15:0];
                    end
                end
            endcase
        end
        // Slot writes arriving from the link: lower word only
        if (qValid && qFunc != rs485_cfg_pkg::FN_READ && qAddr[15:6] == rs485_cfg_pkg::ASSIGN_BASE[15:6]
                && qAddr[0]) begin
            slot_d[qAddr[5:1]] = qData;
        end
        rdata_d = 32'h0000_0000;
        case (address)
            rs485_cfg_pkg::IDX_STATION: rdata_d = {16'h0000, station_q};
            rs485_cfg_pkg::IDX_BAUD: rdata_d = {28'h0, baud_q};
            rs485_cfg_pkg::IDX_ORDER: rdata_d = {30'h0, order_q};
            rs485_cfg_pkg::IDX_PARITY: rdata_d = {30'h0, parity_q};
            rs485_cfg_pkg::IDX_STOP: rdata_d = {30'h0, stop_q};
            rs485_cfg_pkg::IDX_TXWAIT: rdata_d = {24'h0, txWait_q};
            rs485_cfg_pkg::IDX_SILENT: rdata_d = {24'h0, silent_q};
            rs485_cfg_pkg::IDX_TOALARM: rdata_d = {24'h0, toSet_q};
            rs485_cfg_pkg::IDX_ERRALARM: rdata_d = {24'h0, errThr_q};
            rs485_cfg_pkg::IDX_ERRINFO: rdata_d = {24'h0, infoThr_q};
            rs485_cfg_pkg::IDX_ERRMODE: rdata_d = {31'h0, errMode_q};
            rs485_cfg_pkg::IDX_STATUS: rdata_d = {errCnt_q, toMs_q, 13'h0, errInfo, errAlarm,
                timeoutAlarm};
            rs485_cfg_pkg::IDX_ACTIVE: rdata_d = {linkAddr, linkSilent, 4'h0, linkBaud,
                2'h0, linkOrder, linkParity, linkStop};
            default: rdata_d = address[5] ? {16'h0000, slot_q[address[4:0]]} : 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
            station_q <= rs485_cfg_pkg::STATION_RST;
            baud_q <= rs485_cfg_pkg::BAUD_RST;
            order_q <= rs485_cfg_pkg::ORDER_RST;
            parity_q <= rs485_cfg_pkg::PARITY_RST;
            stop_q <= rs485_cfg_pkg::STOP_RST;
            txWait_q <= rs485_cfg_pkg::TXWAIT_RST;
            silent_q <= rs485_cfg_pkg::SILENT_RST;
            toSet_q <= rs485_cfg_pkg::TOALARM_RST;
            errThr_q <= rs485_cfg_pkg::ERRALARM_RST;
            infoThr_q <= rs485_cfg_pkg::ERRINFO_RST;
            errMode_q <= rs485_cfg_pkg::ERRMODE_RST;
            slot_q <= rs485_cfg_pkg::SLOT_RST;
        end else begin
            waitrequest <= wait_d;
            readdata <= rdata_d;
            station_q <= station_d;
            baud_q <= baud_d;
            order_q <= order_d;
            parity_q <= parity_d;
            stop_q <= stop_d;
            txWait_q <= txWait_d;
            silent_q <= silent_d;
            toSet_q <= toSet_d;
            errThr_q <= errThr_d;
            infoThr_q <= infoThr_d;
            errMode_q <= errMode_d;
            slot_q <= slot_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on latch: waits until the switch synchroniser has settled
    always_comb begin
        logic latch;
        latch = (boot_q == rs485_cfg_pkg::BOOT_WAIT - 2'h1);
        boot_d = (boot_q == rs485_cfg_pkg::BOOT_WAIT) ? boot_q : boot_q + 2'h1;
        linkAddr_d = linkAddr;
        linkBaud_d = linkBaud;
        linkOrder_d = linkOrder;
        linkParity_d = linkParity;
        linkStop_d = linkStop;
        linkSilent_d = linkSilent;
        activeWait_d = activeWait_q;
        if (latch) begin
            linkAddr_d = (station_q == rs485_cfg_pkg::STATION_RST) ? swSync
                : station_q[7:0];
            linkBaud_d = baud_q;
            linkOrder_d = order_q;
            linkParity_d = parity_q;
            linkStop_d = stop_q;
            activeWait_d = txWait_q;
            // Zero asks for the interval derived from the bit rate
            if (silent_q != 8'h00) begin
                linkSilent_d = silent_q;
            end else if (baud_q < rs485_cfg_pkg::BAUD_FAST_MIN) begin
                linkSilent_d = rs485_cfg_pkg::SILENT_AUTO_SLOW;
            end else begin
                linkSilent_d = rs485_cfg_pkg::SILENT_AUTO_FAST;
            end
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_q <= 2'h0;
            linkAddr <= 8'h00;
            linkBaud <= rs485_cfg_pkg::BAUD_RST;
            linkOrder <= rs485_cfg_pkg::ORDER_RST;
            linkParity <= rs485_cfg_pkg::PARITY_RST;
            linkStop <= rs485_cfg_pkg::STOP_RST;
            linkSilent <= rs485_cfg_pkg::SILENT_AUTO_FAST;
            activeWait_q <= rs485_cfg_pkg::TXWAIT_RST;
        end else begin
            boot_q <= boot_d;
            linkAddr <= linkAddr_d;
            linkBaud <= linkBaud_d;
            linkOrder <= linkOrder_d;
            linkParity <= linkParity_d;
            linkStop <= linkStop_d;
            linkSilent <= linkSilent_d;
            activeWait_q <= activeWait_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error counting and alarms; detection beats a clear in the same cycle
    logic [3:0] msDiv_q, msDiv_d;
    logic toAlm_d, errAlm_d, info_d;
    always_comb begin
        msDiv_d = msDiv_q;
        toMs_d = toMs_q;
        if (frameOk) begin
            msDiv_d = 4'h0;
            toMs_d = 8'h00;
        end else if (tick) begin
            msDiv_d = (msDiv_q == rs485_cfg_pkg::TICKS_PER_MS - 4'h1) ? 4'h0 : msDiv_q + 4'h1;
            if (msDiv_q == rs485_cfg_pkg::TICKS_PER_MS - 4'h1 && toMs_q != 8'hff) begin
                toMs_d = toMs_q + 8'h01;
            end
        end
        errCnt_d = frameOk ? 8'h00 : errCnt_q;
        if (frameErr && errCnt_q != 8'hff) begin
            errCnt_d = errCnt_q + 8'h01;
        end
        toAlm_d = (timeoutAlarm && !clrAlm) || (toSet_q != 8'h00 && toMs_q >= toSet_q);
        errAlm_d = (errAlarm && !clrAlm) || (errThr_q != 8'h00 && errCnt_q >= errThr_q);
        info_d = (errInfo && !clrAlm) || (infoThr_q != 8'h00 && errCnt_q >= infoThr_q);
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            msDiv_q <= 4'h0;
            toMs_q <= 8'h00;
            errCnt_q <= 8'h00;
            timeoutAlarm <= 1'b0;
            errAlarm <= 1'b0;
            errInfo <= 1'b0;
            exceptMode <= rs485_cfg_pkg::ERRMODE_RST;
        end else begin
            msDiv_q <= msDiv_d;
            toMs_q <= toMs_d;
            errCnt_q <= errCnt_d;
            timeoutAlarm <= toAlm_d;
            errAlarm <= errAlm_d;
            errInfo <= info_d;
            exceptMode <= errMode_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply delay counted in 0.1 ms steps from the request
    logic [7:0] waitCnt_q, waitCnt_d;
    logic waiting_q, waiting_d, go_d;
    always_comb begin
        waitCnt_d = waitCnt_q;
        waiting_d = waiting_q;
        go_d = 1'b0;
        if (replyReq) begin
            waitCnt_d = activeWait_q;
            waiting_d = (activeWait_q != 8'h00);
            go_d = (activeWait_q == 8'h00);
        end else if (waiting_q && replyTick) begin
            waitCnt_d = waitCnt_q - 8'h01;
            if (waitCnt_q == 8'h01) begin
                waiting_d = 1'b0;
                go_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            waitCnt_q <= 8'h00;
            waiting_q <= 1'b0;
            replyGo <= 1'b0;
        end else begin
            waitCnt_q <= waitCnt_d;
            waiting_q <= waiting_d;
            replyGo <= go_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Query address translation; a slot area goes to twice its assignment
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fwdValid <= 1'b0;
            fwdAddr <= 16'h0000;
            fwdFunc <= 8'h00;
            fwdReject <= 1'b0;
        end else begin
            fwdValid <= qValid;
            fwdFunc <= qFunc;
            fwdAddr <= qAddr;
            fwdReject <= 1'b0;
            if (qValid && qAddr[15:6] == rs485_cfg_pkg::AREA_BASE[15:6]) begin
                fwdAddr <= {slot_q[qAddr[5:1]][14:0], qAddr[0]};
                fwdReject <= !(qFunc == rs485_cfg_pkg::FN_READ || qFunc == rs485_cfg_pkg::FN_WRITE
                    || qFunc == rs485_cfg_pkg::FN_RDWR);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wait_pulse_a: assert property ((read || write) && !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    link_hold_a: assert property (boot_q == rs485_cfg_pkg::BOOT_WAIT |=> $stable(linkBaud))
        else $error("active bit rate changed after power-on");
    batch_keep_a: assert property (write && !waitrequest && address == rs485_cfg_pkg::IDX_MAINT
        && writedata[1:0] == rs485_cfg_pkg::CMD_BATCH |=> $stable(baud_q))
        else $error("batch init touched link settings");
    all_init_a: assert property (write && !waitrequest && address == rs485_cfg_pkg::IDX_MAINT
        && writedata[1:0] == rs485_cfg_pkg::CMD_ALL |=> station_q == rs485_cfg_pkg::STATION_RST
        && baud_q == rs485_cfg_pkg::BAUD_RST)
        else $error("full init did not restore link settings");
    switch_addr_a: assert property (boot_q == 2'h2 && station_q == rs485_cfg_pkg::STATION_RST
        |=> linkAddr == $past(swSync))
        else $error("sentinel address did not follow switch");
    reply_wait_a: assert property (replyReq && activeWait_q != 8'h00 |=> !replyGo[*8])
        else $error("reply sent before waiting time");
    timeout_off_a: assert property (toSet_q == 8'h00 && !timeoutAlarm |=> !timeoutAlarm)
        else $error("timeout alarm with monitoring off");
    err_alarm_a: assert property (errThr_q != 8'h00 && errCnt_q >= errThr_q |=> errAlarm)
        else $error("error alarm not raised at threshold");
    info_flag_a: assert property (infoThr_q != 8'h00 && errCnt_q >= infoThr_q |=> errInfo)
        else $error("error information not raised");
    remap_addr_a: assert property (qValid && qAddr[15:6] == rs485_cfg_pkg::AREA_BASE[15:6]
        |=> fwdAddr[15:1] == $past(slot_q[qAddr[5:1]][14:0]))
        else $error("indirect area not remapped");
    // The wait counter itself spans the long delay; the cover only sees its end
    cov_reply: cover property (waiting_q ##1 replyGo);
    cov_remap: cover property (qValid && qAddr[15:6] == rs485_cfg_pkg::AREA_BASE[15:6]);
    cov_alarm: cover property (!errAlarm ##1 errAlarm);
endmodule : rs485_slave_cfg
`default_nettype wire

// ---- modbus_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] func,
    input wire logic [15:0] addr,
    input wire logic [15:0] data,
    output logic qValid,
    output logic [7:0] qFunc,
    output logic [15:0] qAddr,
    output logic [15:0] qData
);
    // One access per strobe; fields scrambled outside it so stale data is never trusted
    always @(posedge clock) begin
        qValid <= go;
        qFunc <= go ? func : ~qFunc;
        qAddr <= go ? addr : ~qAddr;
        qData <= go ? data : ~qData;
    end
endmodule : modbus_master_model
`default_nettype wire

// ---- rs485_slave_comm_config_remap_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rs485_slave_comm_config_remap_tb;
    logic clock, rst, read, write, go, frameErr, waitrequest, fwdValid, fwdReject, errAlarm;
    logic exceptMode, qValid, frameOk, replyReq, replyGo, timeoutAlarm, errInfo;
    logic [5:0] address;
    logic [31:0] writedata, readdata, q;
    logic [7:0] addrSwitch, func, qFunc, fwdFunc, linkAddr, linkSilent;
    logic [15:0] addr, data, qAddr, qData, fwdAddr, d;
    logic [3:0] linkBaud;
    logic [1:0] linkOrder, linkParity, linkStop;
    integer err_count = 0, num_checks = 0, seed = 32'hefca036d, i;
    int mdl [11] = '{'hffff, 4, 0, 1, 0, 30, 0, 0, 3, 3, 1};
    rs485_slave_cfg rs485_slave_cfg_inst (.clock(clock), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .addrSwitch(addrSwitch), .frameOk(frameOk),
        .frameErr(frameErr), .replyReq(replyReq), .replyGo(replyGo), .qValid(qValid),
        .qFunc(qFunc), .qAddr(qAddr),
        .qData(qData), .fwdValid(fwdValid), .fwdAddr(fwdAddr), .fwdFunc(fwdFunc),
        .fwdReject(fwdReject), .linkAddr(linkAddr), .linkBaud(linkBaud), .linkOrder(linkOrder),
        .linkParity(linkParity), .linkStop(linkStop), .linkSilent(linkSilent),
        .timeoutAlarm(timeoutAlarm), .errAlarm(errAlarm), .errInfo(errInfo),
        .exceptMode(exceptMode));
    modbus_master_model modbus_master_model_inst (.clock(clock), .go(go), .func(func),
        .addr(addr), .data(data), .qValid(qValid), .qFunc(qFunc), .qAddr(qAddr), .qData(qData));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Held until waitrequest is sampled low; idle edge after so strobes never merge
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        @(posedge clock iff waitrequest === 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask : bus
    // Forwarded fields are sampled at the edge after they are launched
    task query(input logic [7:0] f, input logic [15:0] a, input logic [15:0] wd);
        func <= f;
        addr <= a;
        data <= wd;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : query
    task wrap_up;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // Watchdog past the default reply wait (about 60k cycles) that dominates the run
    initial begin
        #4_000_000;
        err_count++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst, read, write, go, frameErr, address, writedata, func, addr, data} = '1;
        {read, write, go, frameErr, frameOk, replyReq} = 6'h00;
        addrSwitch = 8'($random(seed));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (5) @(posedge clock);
        chk(linkAddr, addrSwitch);
        chk({linkBaud, linkOrder, linkParity, linkStop}, 32'h0104);
        chk(linkSilent, 8'h12);
        for (i = 0; i < 11; i++) begin
            bus(1'b0, i[5:0], 32'h0);
            chk(q, mdl[i]);
        end
        bus(1'b0, 6'h0e, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 6'h01, 32'h7);
        bus(1'b0, 6'h01, 32'h0);
        chk({q[3:0], linkBaud}, 8'h74);
        bus(1'b1, 6'h0b, 32'h1);
        bus(1'b0, 6'h01, 32'h0);
        chk(q, 32'h7);
        bus(1'b1, 6'h0b, 32'h2);
        bus(1'b0, 6'h01, 32'h0);
        chk(q, 32'h4);
        bus(1'b1, 6'h0a, 32'h0);
        repeat (2) @(posedge clock);
        chk(exceptMode, 1'b0);
        frameErr <= 1'b1;
        repeat (3) @(posedge clock);
        frameErr <= 1'b0;
        repeat (3) @(posedge clock);
        chk(errAlarm, 1'b1);
        // Status word: three errors counted, both error flags up, timeout off
        bus(1'b0, 6'h0c, 32'h0);
        chk({q[31:24], q[2:0]}, 11'h01e);
        // A good frame clears the count so the clear command is not re-set at once
        frameOk <= 1'b1;
        @(posedge clock);
        frameOk <= 1'b0;
        bus(1'b1, 6'h0b, 32'h3);
        chk({timeoutAlarm, errAlarm, errInfo}, 3'b000);
        i = $unsigned($random(seed)) % 32;
        d = 16'($random(seed));
        query(8'h03, 16'(16'h1301 + 2 * i), 16'h0);
        chk({fwdValid, fwdReject, fwdAddr}, {2'b10, rs485_cfg_pkg::SLOT_RST[i][14:0], 1'b1});
        query(8'h10, 16'(16'h1201 + 2 * i), d);
        query(8'h17, 16'(16'h1300 + 2 * i), 16'h0);
        chk({fwdFunc, fwdAddr}, {8'h17, d[14:0], 1'b0});
        query(8'h06, 16'(16'h1300 + 2 * i), 16'h0);
        chk(fwdReject, 1'b1);
        // Reply request at edge E; go is seen at the edge after E + wait * tick + 1
        replyReq <= 1'b1;
        @(posedge clock);
        replyReq <= 1'b0;
        i = 0;
        while (replyGo !== 1'b1 && i < 70000) begin
            @(posedge clock);
            i++;
        end
        chk(i, rs485_cfg_pkg::TXWAIT_RST * rs485_cfg_pkg::TICK_CYCLES + 2);
        wrap_up();
    end
endmodule : rs485_slave_comm_config_remap_tb
`default_nettype wire
